/* File: design/sgic_pkg.sv */
package sgic_pkg;

  // Indirect address space width and register locations
  localparam int          ADDR_W            = 21;
  localparam logic [20:0] ADDR_LINK_CONTROL = 21'h1F0000;
  localparam logic [20:0] ADDR_LINK_STATUS  = 21'h1F0001;
  localparam logic [20:0] ADDR_IDENT_ONE    = 21'h1F0002;
  localparam logic [20:0] ADDR_IDENT_TWO    = 21'h1F0003;
  localparam logic [20:0] ADDR_NEG_ADVERT   = 21'h1F0004;
  localparam logic [20:0] ADDR_PARTNER_ABIL = 21'h1F0005;
  localparam logic [20:0] ADDR_NEG_EXPAN    = 21'h1F0006;
  localparam logic [20:0] ADDR_VENDOR_DIG   = 21'h1F8000;
  localparam logic [20:0] ADDR_NEG_CONTROL  = 21'h1F8001;
  localparam logic [20:0] ADDR_NEG_RESULT   = 21'h1F8002;

  // Control register field positions
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK   = 14;
  localparam int BIT_SPEED_LO   = 13;
  localparam int BIT_AN_ENABLE  = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX     = 8;
  localparam int BIT_SPEED_HI   = 6;

  // Writable control bits and value after reset
  localparam logic [15:0] CTRL_WR_MASK   = 16'hFB40;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h1140;

  // Reset values of the other writable registers, and the fixed status bits
  localparam logic [15:0] ADVERT_RESET_VAL  = 16'h0000;
  localparam logic [15:0] VENDOR_RESET_VAL  = 16'h0000;
  localparam logic [15:0] NEGCTL_RESET_VAL  = 16'h0000;
  localparam logic [15:0] STATUS_FIXED_BITS = 16'h0188;

  // Cycles the block-wide soft reset pulse stands
  localparam int SOFT_RESET_CYCLES = 4;

  // Speed codes formed as {bit 6, bit 13}
  typedef enum logic [1:0] {
    SGIC_SPEED_10   = 2'b00,
    SGIC_SPEED_100  = 2'b01,
    SGIC_SPEED_1000 = 2'b10,
    SGIC_SPEED_RSVD = 2'b11
  } sgic_speed_t;

endpackage : sgic_pkg

/* File: design/sgic_portal_if.sv */
`timescale 1ns/1ns
// Decoded portal access handed from top to register file
interface sgic_portal_if;
  logic        wr;
  logic        rd;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        hit;
  modport top  (output wr, output rd, output addr, output wdata, input rdata, input hit);
  modport regs (input wr, input rd, input addr, input wdata, output rdata, output hit);
endinterface : sgic_portal_if

/* File: design/sgic_regfile.sv */
`timescale 1ns/1ns
module sgic_regfile
  import sgic_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        soft_clear,
  // Portal access
  sgic_portal_if.regs      port,
  // Link side status
  input  wire logic [15:0] partner_ability,
  input  wire logic [15:0] neg_result,
  input  wire logic        an_complete,
  input  wire logic        remote_fault,
  input  wire logic        an_restart_done,
  // Control out
  output logic      [15:0] ctrl
);

  logic [15:0] advert;
  logic [15:0] vendor;
  logic [15:0] negctl;
  logic        fault_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; soft reset returns defaults, bit 15 self clears
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_clear) begin
      ctrl <= CTRL_RESET_VAL;
    end else if (port.wr && port.addr == ADDR_LINK_CONTROL) begin
      ctrl <= port.wdata & CTRL_WR_MASK;
    end else if (an_restart_done) begin
      ctrl[BIT_AN_RESTART] <= 1'b0;
    end
  end

  // Other writable registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_clear) begin
      advert <= ADVERT_RESET_VAL;
      vendor <= VENDOR_RESET_VAL;
      negctl <= NEGCTL_RESET_VAL;
    end else if (port.wr) begin
      if (port.addr == ADDR_NEG_ADVERT)  advert <= port.wdata;
      if (port.addr == ADDR_VENDOR_DIG)  vendor <= port.wdata;
      if (port.addr == ADDR_NEG_CONTROL) negctl <= port.wdata;
    end
  end

  // Remote fault latches high until status read; a new event wins over the read
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_clear) begin
      fault_latch <= 1'b0;
    end else if (remote_fault) begin
      fault_latch <= 1'b1;
    end else if (port.rd && port.addr == ADDR_LINK_STATUS) begin
      fault_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode of the 21-bit indirect space
  always_comb begin
    port.hit   = 1'b1;
    port.rdata = 16'h0000;
    case (port.addr)
      ADDR_LINK_CONTROL: port.rdata = ctrl;
      ADDR_LINK_STATUS:  port.rdata = STATUS_FIXED_BITS | {10'h000, an_complete,
                                      fault_latch, 4'h0};
      ADDR_IDENT_ONE:    port.rdata = 16'h0000; // Arbitrary identity value
      ADDR_IDENT_TWO:    port.rdata = 16'h0000; // Arbitrary identity value
      ADDR_NEG_ADVERT:   port.rdata = advert;
      ADDR_PARTNER_ABIL: port.rdata = partner_ability;
      ADDR_NEG_EXPAN:    port.rdata = 16'h0000;
      ADDR_VENDOR_DIG:   port.rdata = vendor;
      ADDR_NEG_CONTROL:  port.rdata = negctl;
      ADDR_NEG_RESULT:   port.rdata = neg_result;
      default:           port.hit   = 1'b0;
    endcase
  end

endmodule : sgic_regfile

/* File: design/sgic_top.sv */
// How it works
// - Decode a 21-bit indirect address space
// - Access only via address and data portals
// - Standard and vendor registers at fixed addresses
// - Control register is 16 bits, eight of them writable
// - Bit 15 resets block, then self-clears
// - Bit 14 loops fabric data back before the PCS, PCS transmit held idle
// - Speed code is bits 6 and 13
// - Speed high bit resets to one
`timescale 1ns/1ns
module sgic_top
  import sgic_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Address portal
  input  wire logic        addr_wr,
  input  wire logic [20:0] addr_wdata,
  output logic      [20:0] addr_rdata,
  // Data portal
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [15:0] data_wdata,
  output logic      [15:0] data_rdata,
  output logic             data_valid,
  output logic             data_miss,
  // Link status from PCS (asynchronous to core)
  input  wire logic [15:0] partner_ability,
  input  wire logic [15:0] neg_result,
  input  wire logic        an_complete,
  input  wire logic        remote_fault,
  // Fabric transmit and receive path
  input  wire logic [7:0]  fab_tx_data,
  input  wire logic        fab_tx_en,
  output logic      [7:0]  fab_rx_data,
  output logic             fab_rx_dv,
  output logic      [7:0]  pcs_tx_data,
  output logic             pcs_tx_en,
  input  wire logic [7:0]  pcs_rx_data,
  input  wire logic        pcs_rx_dv,
  // Control outputs
  output logic             block_reset,
  output logic             loopback_en,
  output logic [1:0]       speed_sel,
  output logic             full_duplex,
  output logic             an_enable,
  output logic             power_down,
  output logic             an_restart
);

  // Decoded access toward the register file
  sgic_portal_if port ();

  logic [15:0] ctrl;
  logic [20:0] addr_q;
  logic        soft_clear;
  logic [2:0]  rst_cnt;
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic [15:0] abil_s;
  logic [15:0] abil_s1;
  logic [15:0] result_s;
  logic        done_s;
  logic        fault_s;
  logic [8:0]  rx_s1;
  logic [8:0]  rx_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Address portal holds target until software changes it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_q <= 21'h000000;
    end else if (addr_wr) begin
      addr_q <= addr_wdata;
    end
  end

  // Data portal drives the register file
  assign port.addr  = addr_q;
  assign port.wr    = data_wr;
  assign port.rd    = data_rd;
  assign port.wdata = data_wdata;

  // Registered read answer one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_rdata <= 16'h0000;
      data_valid <= 1'b0;
      data_miss  <= 1'b0;
    end else begin
      data_valid <= data_rd;
      data_miss  <= (data_rd || data_wr) && !port.hit;
      if (data_rd) data_rdata <= port.rdata; // Held until the next read
    end
  end

  // Address portal readback; lags one cycle so it stays a plain flop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_rdata <= 21'h000000;
    end else begin
      addr_rdata <= addr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset: a write of bit 15 starts a fixed-length block reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_cnt <= 3'h0;
    end else if (data_wr && addr_q == ADDR_LINK_CONTROL && data_wdata[BIT_SOFT_RESET]) begin
      rst_cnt <= 3'(SOFT_RESET_CYCLES);
    end else if (rst_cnt != 3'h0) begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end
  assign soft_clear = (rst_cnt == 3'h1); // Defaults restored as pulse ends

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for status coming from the link side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= 18'h00000;
      sync2 <= 18'h00000;
    end else begin
      sync1 <= {an_complete, remote_fault, neg_result};
      sync2 <= sync1;
    end
  end
  // Partner word kept apart; quasi-static once negotiation completes
  // Still two flops: a word caught mid-change must not reach a read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      abil_s1 <= 16'h0000;
      abil_s  <= 16'h0000;
    end else begin
      abil_s1 <= partner_ability;
      abil_s  <= abil_s1;
    end
  end
  assign done_s   = sync2[17];
  assign fault_s  = sync2[16];
  assign result_s = sync2[15:0];

  sgic_regfile u_regs (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .soft_clear      (soft_clear),
    .port            (port),
    .partner_ability (abil_s),
    .neg_result      (result_s),
    .an_complete     (done_s),
    .remote_fault    (fault_s),
    .an_restart_done (an_restart),
    .ctrl            (ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link control outputs, all from flip-flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      block_reset <= 1'b0;
      loopback_en <= 1'b0;
      speed_sel   <= SGIC_SPEED_1000;
      full_duplex <= 1'b1;
    end else begin
      block_reset <= (rst_cnt != 3'h0);
      loopback_en <= ctrl[BIT_LOOPBACK];
      speed_sel   <= {ctrl[BIT_SPEED_HI], ctrl[BIT_SPEED_LO]};
      full_duplex <= ctrl[BIT_DUPLEX];
    end
  end

  // Negotiation and power controls, kept apart from the link controls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      an_enable   <= 1'b1;
      power_down  <= 1'b0;
      an_restart  <= 1'b0;
    end else begin
      an_enable   <= ctrl[BIT_AN_ENABLE];
      power_down  <= ctrl[BIT_POWER_DOWN];
      // Feeds back as the clear of the restart bit, so the pulse is one cycle
      an_restart  <= ctrl[BIT_AN_RESTART] && !an_restart; // One pulse, then cleared
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive from PCS passes two flops; loopback turns fabric data around
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_s1 <= 9'h000;
      rx_s2 <= 9'h000;
    end else begin
      rx_s1 <= {pcs_rx_dv, pcs_rx_data};
      rx_s2 <= rx_s1;
    end
  end

  // Fabric receive picks loopback or link; soft reset flushes both ways
  always_ff @(posedge ref_clk) begin
    if (!rst_n || block_reset) begin
      fab_rx_data <= 8'h00;
      fab_rx_dv   <= 1'b0;
      pcs_tx_data <= 8'h00;
      pcs_tx_en   <= 1'b0;
    end else if (loopback_en) begin
      fab_rx_data <= fab_tx_data;
      fab_rx_dv   <= fab_tx_en;
      pcs_tx_data <= 8'h00; // Link held idle while looped
      pcs_tx_en   <= 1'b0;
    end else begin
      fab_rx_data <= rx_s2[7:0];
      fab_rx_dv   <= rx_s2[8];
      pcs_tx_data <= fab_tx_data;
      pcs_tx_en   <= fab_tx_en;
    end
  end

endmodule : sgic_top

/* File: dv/sgic_partner.sv */
`timescale 1ns/1ns
module sgic_partner #(
  parameter logic [15:0] ABILITY = 16'h4C01,
  parameter logic [15:0] NEG_RES = 16'hD801
) (
  // Clock and fault request
  input  wire logic        ref_clk,
  input  wire logic        fault_req,
  // From the block
  input  wire logic [7:0]  pcs_tx_data,
  input  wire logic        pcs_tx_en,
  // Toward the block
  output logic      [7:0]  pcs_rx_data,
  output logic             pcs_rx_dv,
  output logic      [15:0] partner_ability,
  output logic      [15:0] neg_result,
  output logic             an_complete,
  output logic             remote_fault
);
  logic [5:0] neg_cnt = 6'h00;
  initial pcs_rx_data = 8'hA5;
  initial pcs_rx_dv = 1'b0;
  // Echo frames; idle line toggles so stale data never looks valid
  always @(posedge ref_clk) begin
    pcs_rx_dv <= pcs_tx_en;
    pcs_rx_data <= pcs_tx_en ? pcs_tx_data : ~pcs_rx_data;
    if (neg_cnt != 6'h3F) neg_cnt <= neg_cnt + 6'h01;
  end
  // Negotiation finishes some cycles after start
  assign an_complete = (neg_cnt == 6'h3F);
  assign remote_fault = fault_req;
  assign partner_ability = ABILITY;
  assign neg_result = NEG_RES;
endmodule : sgic_partner

/* File: dv/sgic_chk.sv */
`timescale 1ns/1ns
module sgic_chk
  import sgic_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Portal
  input wire logic [20:0] addr_rdata,
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic [15:0] data_wdata,
  input wire logic        data_valid,
  input wire logic        data_miss,
  // Control
  input wire logic        pcs_tx_en,
  input wire logic        block_reset,
  input wire logic        loopback_en,
  input wire logic [1:0]  speed_sel,
  input wire logic        full_duplex,
  input wire logic        an_enable,
  input wire logic        power_down,
  input wire logic        an_restart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic csel = (addr_rdata == ADDR_LINK_CONTROL);
  // Control write reaches the outputs two cycles on
  property p_wr;
    logic [15:0] w;
    (data_wr && csel && !data_wdata[15], w = data_wdata) |-> ##2
      (loopback_en == w[14] && speed_sel == {w[6], w[13]} && an_enable == w[12] &&
       full_duplex == w[8] && power_down == w[11]);
  endproperty
  AST_WR_CTRL: assert property (p_wr) else $error("control write not applied");
  AST_RD_VALID: assert property (data_rd |=> data_valid) else $error("no read answer");
  AST_VALID_CAUSE: assert property (data_valid |-> $past(data_rd)) else $error("stray valid");
  AST_MISS_CAUSE: assert property (data_miss |-> $past(data_rd) || $past(data_wr))
    else $error("stray miss");
  AST_SOFT_CLR: assert property (data_wr && csel && data_wdata[15] |-> ##[1:2] block_reset)
    else $error("soft reset not started");
  AST_RST_PULSE: assert property ($rose(block_reset) |-> block_reset[*4] ##1 !block_reset)
    else $error("soft reset pulse length");
  AST_LOOP: assert property (loopback_en && $past(loopback_en) |-> !pcs_tx_en)
    else $error("transmit during loopback");
  AST_RESTART: assert property (data_wr && csel && data_wdata[9] && !data_wdata[15] |->
    ##2 an_restart ##1 !an_restart) else $error("restart pulse wrong");
  AST_RESET_VALS: assert property (disable iff (1'b0) !rst_n |=> speed_sel == 2'b10 && full_duplex && !loopback_en)
    else $error("reset defaults wrong");
  // Main scenarios
  COV_RD: cover property (data_rd ##1 data_valid);
  COV_SOFT: cover property ($rose(block_reset));
  COV_LOOP: cover property ($rose(loopback_en));
  COV_RESTART: cover property ($rose(an_restart));
endmodule : sgic_chk

/* File: dv/sgic_top_tb.sv */
`timescale 1ns/1ns
module sgic_top_tb;
  import sgic_pkg::*;
  localparam logic [15:0] ABIL = 16'h4C01;
  localparam logic [15:0] NEGR = 16'hD801;
  logic        ref_clk = 1'b0, rst_n = 1'b0, addr_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic        fab_tx_en = 1'b0, fault_req = 1'b0, rm;
  logic [20:0] addr_wdata = 21'h000000, addr_rdata;
  logic [15:0] data_wdata = 16'h0000, data_rdata, partner_ability, neg_result, rv;
  logic [7:0]  fab_tx_data = 8'h00, fab_rx_data, pcs_tx_data, pcs_rx_data;
  logic        data_valid, data_miss, an_complete, remote_fault, fab_rx_dv, pcs_tx_en;
  logic        pcs_rx_dv, block_reset, loopback_en, full_duplex, an_enable, power_down;
  logic        an_restart;
  logic [1:0]  speed_sel;
  logic [20:0] wa [3] = '{ADDR_NEG_ADVERT, ADDR_VENDOR_DIG, ADDR_NEG_CONTROL};
  int          bad_count = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  sgic_top dut_u (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .addr_wr         (addr_wr),
    .addr_wdata      (addr_wdata),
    .addr_rdata      (addr_rdata),
    .data_wr         (data_wr),
    .data_rd         (data_rd),
    .data_wdata      (data_wdata),
    .data_rdata      (data_rdata),
    .data_valid      (data_valid),
    .data_miss       (data_miss),
    .partner_ability (partner_ability),
    .neg_result      (neg_result),
    .an_complete     (an_complete),
    .remote_fault    (remote_fault),
    .fab_tx_data     (fab_tx_data),
    .fab_tx_en       (fab_tx_en),
    .fab_rx_data     (fab_rx_data),
    .fab_rx_dv       (fab_rx_dv),
    .pcs_tx_data     (pcs_tx_data),
    .pcs_tx_en       (pcs_tx_en),
    .pcs_rx_data     (pcs_rx_data),
    .pcs_rx_dv       (pcs_rx_dv),
    .block_reset     (block_reset),
    .loopback_en     (loopback_en),
    .speed_sel       (speed_sel),
    .full_duplex     (full_duplex),
    .an_enable       (an_enable),
    .power_down      (power_down),
    .an_restart      (an_restart)
  );
  sgic_partner #(.ABILITY(ABIL), .NEG_RES(NEGR)) partner_u (
    .ref_clk         (ref_clk),
    .fault_req       (fault_req),
    .pcs_tx_data     (pcs_tx_data),
    .pcs_tx_en       (pcs_tx_en),
    .pcs_rx_data     (pcs_rx_data),
    .pcs_rx_dv       (pcs_rx_dv),
    .partner_ability (partner_ability),
    .neg_result      (neg_result),
    .an_complete     (an_complete),
    .remote_fault    (remote_fault)
  );
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Address settles two cycles before the data access
  task automatic set_addr(input logic [20:0] a);
    @(posedge ref_clk);
    addr_wr <= 1'b1;
    addr_wdata <= a;
    @(posedge ref_clk);
    addr_wr <= 1'b0;
    tick(2);
  endtask : set_addr
  task automatic reg_wr(input logic [20:0] a, input logic [15:0] d);
    set_addr(a);
    data_wr <= 1'b1;
    data_wdata <= d;
    @(posedge ref_clk);
    data_wr <= 1'b0;
    #1 rm = data_miss;
    tick(3);
  endtask : reg_wr
  task automatic reg_rd(input logic [20:0] a);
    set_addr(a);
    data_rd <= 1'b1;
    @(posedge ref_clk);
    data_rd <= 1'b0;
    #1 rv = data_rdata;
    rm = data_miss;
  endtask : reg_rd
  // Bounded wait for a settled receive strobe
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    fab_tx_en <= 1'b1;
    fab_tx_data <= b;
    @(posedge ref_clk);
    fab_tx_en <= 1'b0;
    // Look just after each edge, never in the step that launches the strobe
    #1;
    for (int n = 0; n < 12 && fab_rx_dv !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(fab_rx_dv, 1'b1);
    chk(fab_rx_data, b);
  endtask : send
  ////////////////////////////////////////////////////////////////
  task automatic t_map;
    reg_rd(ADDR_LINK_CONTROL);
    chk(rv, CTRL_RESET_VAL);
    chk(speed_sel, SGIC_SPEED_1000);
    reg_rd(ADDR_PARTNER_ABIL);
    chk(rv, ABIL);
    reg_rd(ADDR_NEG_RESULT);
    chk(rv, NEGR);
    reg_wr(ADDR_IDENT_ONE, 16'hFFFF);
    reg_rd(ADDR_IDENT_ONE);
    chk(rv, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      reg_wr(wa[i], 16'hA5C0 + 16'(i));
      reg_rd(wa[i]);
      chk({rm, rv}, {1'b0, 16'hA5C0 + 16'(i)});
    end
    reg_rd(21'h1F0007);
    chk(rm, 1'b1);
    reg_rd(21'h0F0000);
    chk(rm, 1'b1);
    reg_wr(21'h1F8003, 16'h1234);
    chk(rm, 1'b1);
  endtask : t_map
  // Fault latches until the status read
  task automatic t_status;
    for (int n = 0; n < 100 && an_complete !== 1'b1; n++) tick(1);
    fault_req <= 1'b1;
    tick(1);
    fault_req <= 1'b0;
    tick(4);
    reg_rd(ADDR_LINK_STATUS);
    chk(rv, STATUS_FIXED_BITS | 16'h0030);
    reg_rd(ADDR_LINK_STATUS);
    chk(rv, STATUS_FIXED_BITS | 16'h0020);
  endtask : t_status
  // Speed set by hand once negotiation is done
  task automatic t_speed;
    logic [15:0] w;
    for (int i = 0; i < 3; i++) begin
      w = 16'h1100 | (i[1] ? 16'h0040 : 16'h0000) | (i[0] ? 16'h2000 : 16'h0000);
      reg_wr(ADDR_LINK_CONTROL, w);
      chk(speed_sel, i[1:0]);
      reg_rd(ADDR_LINK_CONTROL);
      chk(rv, w);
    end
  endtask : t_speed
  task automatic t_loop;
    reg_wr(ADDR_LINK_CONTROL, 16'h5140);
    chk(loopback_en, 1'b1);
    send(8'h5A);
    reg_wr(ADDR_LINK_CONTROL, 16'h1140);
    send(8'hC3);
  endtask : t_loop
  task automatic t_soft;
    reg_wr(ADDR_NEG_ADVERT, 16'h00FF);
    reg_wr(ADDR_LINK_CONTROL, 16'h3100);
    reg_wr(ADDR_LINK_CONTROL, 16'h9100);
    for (int n = 0; n < 20 && block_reset !== 1'b0; n++) tick(1);
    tick(2);
    reg_rd(ADDR_LINK_CONTROL);
    chk(rv, CTRL_RESET_VAL);
    reg_rd(ADDR_NEG_ADVERT);
    chk(rv, ADVERT_RESET_VAL);
  endtask : t_soft
  // Restart bit clears itself; a mid-run reset brings back the defaults
  task automatic t_reset;
    reg_wr(ADDR_LINK_CONTROL, 16'h1340);
    reg_rd(ADDR_LINK_CONTROL);
    chk(rv, 16'h1140);
    reg_wr(ADDR_LINK_CONTROL, 16'h6100);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    chk({loopback_en, speed_sel, full_duplex}, 4'b0101);
    reg_rd(ADDR_LINK_CONTROL);
    chk(rv, CTRL_RESET_VAL);
  endtask : t_reset
  task automatic results;
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // Main sequence after eight reset cycles
  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    t_map();
    t_status();
    t_speed();
    t_loop();
    t_soft();
    t_reset();
    results();
  end
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    bad_count++;
    results();
  end
endmodule : sgic_top_tb
bind sgic_top sgic_chk chk_u (
  .ref_clk     (ref_clk),
  .rst_n       (rst_n),
  .addr_rdata  (addr_rdata),
  .data_wr     (data_wr),
  .data_rd     (data_rd),
  .data_wdata  (data_wdata),
  .data_valid  (data_valid),
  .data_miss   (data_miss),
  .pcs_tx_en   (pcs_tx_en),
  .block_reset (block_reset),
  .loopback_en (loopback_en),
  .speed_sel   (speed_sel),
  .full_duplex (full_duplex),
  .an_enable   (an_enable),
  .power_down  (power_down),
  .an_restart  (an_restart)
);
